// ### lmrc_top.sv
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module lmrc_top #(
	parameter int SEC_CYCLES = lmrc_pkg::SEC_CYCLES_DEF
) (
	input wire logic MCLK,
	input wire logic RST_B,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic signed [15:0] INST_CURRENT,
	input wire logic signed [15:0] MEAN_CURRENT,
	input wire logic [15:0] CELL_VOLTAGE,
	input wire logic [15:0] VOLT_SLOPE,
	input wire logic [15:0] QMAX_NEW,
	input wire logic QMAX_NEW_VALID,
	input wire logic [15:0] LEFT_RAW_CHARGE,
	input wire logic [15:0] LEFT_RAW_ENERGY,
	output logic [15:0] LEFT_CAPACITY,
	output logic [15:0] LEFT_ENERGY,
	output logic LOAD_MODEL_FLAG,
	output logic signed [15:0] LOAD_RATE,
	output logic DISCHARGING,
	output logic CHARGING,
	output logic RELAXED,
	output logic OCV_TAKE,
	output logic [15:0] OCV_VOLTAGE,
	output logic [15:0] QMAX,
	output logic IRQ
);
	// ========================================
	// Declarations.
	logic model, next_model;
	logic [2:0] sel, next_sel;
	logic [15:0] dsg_thr, next_dsg_thr, chg_thr, next_chg_thr, quit, next_quit;
	logic [15:0] dsg_rlx, next_dsg_rlx, chg_rlx, next_chg_rlx, quit_rlx, next_quit_rlx;
	logic [15:0] user_rate, next_user_rate, hypo_rate, next_hypo_rate;
	logic [15:0] rsv_chg, next_rsv_chg, rsv_en, next_rsv_en;
	logic [15:0] des_cap, next_des_cap, des_en, next_des_en;
	logic [15:0] next_qmax;
	logic [7:0] learned, next_learned;
	logic [5:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask, ev;
	logic [31:0] next_prdata, rd_val;
	logic err, next_err, hit;
	logic wr, setup_rd, acc_rd;
	logic [31:0] sec_cnt, next_sec_cnt;
	logic tick;
	logic signed [16:0] i_ext, m_ext, m_abs;
	logic dsg_now, chg_now, quiet, busy;
	lmrc_pkg::lmrc_relax_t rstate, next_rstate;
	logic [15:0] quiet_s, next_quiet_s, busy_s, next_busy_s, relax_s, next_relax_s;
	logic ocv_done, next_ocv_done, next_ocv_take, qmax_upd;
	logic [15:0] next_ocv_v;
	logic next_dsg, next_chg;
	logic signed [23:0] filt, next_filt;
	logic signed [24:0] f_diff;
	logic signed [33:0] f_prod, p_full, mp_full, fp_full;
	logic signed [15:0] p_cw, mp_cw, fp_cw, run_i, last_i, run_p, last_p;
	logic signed [15:0] next_rate;

	// ========================================
	// Bus slave with registered read data.
	assign wr = PSEL && PENABLE && PWRITE;
	assign setup_rd = PSEL && !PENABLE && !PWRITE;
	assign acc_rd = PSEL && PENABLE && !PWRITE;
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && err;

	always_comb begin
		hit = 1'b1;
		rd_val = '0;
		case (PADDR)
			lmrc_pkg::A_CTRL: begin
				rd_val[lmrc_pkg::CTRL_MODEL_BIT] = model;
				rd_val[lmrc_pkg::CTRL_SEL_LO +: lmrc_pkg::SEL_W] = sel;
			end
			lmrc_pkg::A_DSG_THR: rd_val[15:0] = dsg_thr;
			lmrc_pkg::A_CHG_THR: rd_val[15:0] = chg_thr;
			lmrc_pkg::A_QUIT: rd_val[15:0] = quit;
			lmrc_pkg::A_DSG_RLX: rd_val[15:0] = dsg_rlx;
			lmrc_pkg::A_CHG_RLX: rd_val[15:0] = chg_rlx;
			lmrc_pkg::A_QUIT_RLX: rd_val[15:0] = quit_rlx;
			lmrc_pkg::A_USER_RATE: rd_val[15:0] = user_rate;
			lmrc_pkg::A_HYPO_RATE: rd_val[15:0] = hypo_rate;
			lmrc_pkg::A_RESERVE: rd_val = {rsv_en, rsv_chg};
			lmrc_pkg::A_DESIGN: rd_val = {des_en, des_cap};
			lmrc_pkg::A_QMAX: rd_val[15:0] = QMAX;
			lmrc_pkg::A_LEARN: rd_val[7:0] = learned;
			lmrc_pkg::A_STATUS: begin
				rd_val[lmrc_pkg::ST_MODEL] = LOAD_MODEL_FLAG;
				rd_val[lmrc_pkg::ST_DSG] = DISCHARGING;
				rd_val[lmrc_pkg::ST_CHG] = CHARGING;
				rd_val[lmrc_pkg::ST_RELAX] = RELAXED;
				rd_val[lmrc_pkg::ST_OCV] = ocv_done;
			end
			lmrc_pkg::A_RATE: rd_val[15:0] = LOAD_RATE;
			lmrc_pkg::A_AVG_I: rd_val[15:0] = last_i;
			lmrc_pkg::A_AVG_P: rd_val[15:0] = last_p;
			lmrc_pkg::A_IRQ_STAT: rd_val[5:0] = irq_stat;
			lmrc_pkg::A_IRQ_MASK: rd_val[5:0] = irq_mask;
			lmrc_pkg::A_OCV: rd_val[15:0] = OCV_VOLTAGE;
			default: hit = 1'b0;
		endcase
	end

	assign IRQ = |(irq_stat & irq_mask);

	// ========================================
	// Register file and capacity learning.
	assign qmax_upd = (rstate == lmrc_pkg::RLX_REST) && ocv_done && QMAX_NEW_VALID
		&& (VOLT_SLOPE < lmrc_pkg::SLOPE_MAX_UV);

	always_comb begin
		next_model = model;
		next_sel = sel;
		next_dsg_thr = dsg_thr;
		next_chg_thr = chg_thr;
		next_quit = quit;
		next_dsg_rlx = dsg_rlx;
		next_chg_rlx = chg_rlx;
		next_quit_rlx = quit_rlx;
		next_user_rate = user_rate;
		next_hypo_rate = hypo_rate;
		next_rsv_chg = rsv_chg;
		next_rsv_en = rsv_en;
		next_des_cap = des_cap;
		next_des_en = des_en;
		next_qmax = QMAX;
		next_learned = learned;
		next_irq_mask = irq_mask;
		next_irq_stat = irq_stat;
		next_prdata = PRDATA;
		next_err = err;
		if (PSEL && !PENABLE) begin
			next_err = !hit;
			if (setup_rd) begin
				next_prdata = rd_val;
			end
		end
		if (wr && hit) begin
			case (PADDR)
				lmrc_pkg::A_CTRL: begin
					next_model = PWDATA[lmrc_pkg::CTRL_MODEL_BIT];
					if (PWDATA[lmrc_pkg::CTRL_SEL_LO +: lmrc_pkg::SEL_W] <= lmrc_pkg::SEL_MAX) begin
						next_sel = PWDATA[lmrc_pkg::CTRL_SEL_LO +: lmrc_pkg::SEL_W];
					end
				end
				lmrc_pkg::A_DSG_THR: next_dsg_thr = PWDATA[15:0];
				lmrc_pkg::A_CHG_THR: next_chg_thr = PWDATA[15:0];
				lmrc_pkg::A_QUIT: next_quit = PWDATA[15:0];
				lmrc_pkg::A_DSG_RLX: next_dsg_rlx = PWDATA[15:0];
				lmrc_pkg::A_CHG_RLX: next_chg_rlx = PWDATA[15:0];
				lmrc_pkg::A_QUIT_RLX: next_quit_rlx = PWDATA[15:0];
				lmrc_pkg::A_USER_RATE: next_user_rate = PWDATA[15:0];
				lmrc_pkg::A_HYPO_RATE: next_hypo_rate = PWDATA[15:0];
				lmrc_pkg::A_RESERVE: begin
					next_rsv_chg = PWDATA[15:0];
					next_rsv_en = PWDATA[31:16];
				end
				lmrc_pkg::A_DESIGN: begin
					next_des_cap = PWDATA[15:0];
					next_des_en = PWDATA[31:16];
				end
				lmrc_pkg::A_QMAX: next_qmax = PWDATA[15:0];
				lmrc_pkg::A_LEARN: next_learned[lmrc_pkg::LEARN_BIT] = PWDATA[lmrc_pkg::LEARN_BIT];
				lmrc_pkg::A_IRQ_MASK: next_irq_mask = PWDATA[5:0];
				default: next_err = err;
			endcase
		end
		if (qmax_upd) begin
			next_qmax = QMAX_NEW;
			next_learned[lmrc_pkg::LEARN_BIT] = 1'b1;
		end
		if (acc_rd && PADDR == lmrc_pkg::A_IRQ_STAT) begin
			next_irq_stat = irq_stat & ~PRDATA[5:0];
		end
		next_irq_stat = next_irq_stat | ev;
	end

	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			model <= lmrc_pkg::MODEL_RST;
			sel <= lmrc_pkg::SEL_RST;
			dsg_thr <= lmrc_pkg::DSG_THR_RST;
			chg_thr <= lmrc_pkg::CHG_THR_RST;
			quit <= lmrc_pkg::QUIT_RST;
			dsg_rlx <= lmrc_pkg::DSG_RLX_RST;
			chg_rlx <= lmrc_pkg::CHG_RLX_RST;
			quit_rlx <= lmrc_pkg::QUIT_RLX_RST;
			user_rate <= '0;
			hypo_rate <= '0;
			rsv_chg <= '0;
			rsv_en <= '0;
			des_cap <= lmrc_pkg::QMAX_RST;
			des_en <= '0;
			QMAX <= lmrc_pkg::QMAX_RST;
			learned <= '0;
			irq_stat <= '0;
			irq_mask <= '0;
			PRDATA <= '0;
			err <= 1'b0;
		end else begin
			model <= next_model;
			sel <= next_sel;
			dsg_thr <= next_dsg_thr;
			chg_thr <= next_chg_thr;
			quit <= next_quit;
			dsg_rlx <= next_dsg_rlx;
			chg_rlx <= next_chg_rlx;
			quit_rlx <= next_quit_rlx;
			user_rate <= next_user_rate;
			hypo_rate <= next_hypo_rate;
			rsv_chg <= next_rsv_chg;
			rsv_en <= next_rsv_en;
			des_cap <= next_des_cap;
			des_en <= next_des_en;
			QMAX <= next_qmax;
			learned <= next_learned;
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			PRDATA <= next_prdata;
			err <= next_err;
		end
	end

	// ========================================
	// Flow classification and relaxation.
	assign tick = (sec_cnt == 32'(SEC_CYCLES - 1));
	assign i_ext = {INST_CURRENT[15], INST_CURRENT};
	assign m_ext = {MEAN_CURRENT[15], MEAN_CURRENT};
	assign m_abs = m_ext[16] ? -m_ext : m_ext;
	assign dsg_now = (-i_ext) > $signed({1'b0, dsg_thr});
	assign chg_now = i_ext > $signed({1'b0, chg_thr});
	assign quiet = m_abs < $signed({1'b0, quit});
	assign busy = m_abs > $signed({1'b0, quit});
	assign next_dsg = dsg_now;
	assign next_chg = chg_now;
	assign ev = {qmax_upd, next_ocv_take,
		(rstate == lmrc_pkg::RLX_REST) && (next_rstate == lmrc_pkg::RLX_FLOW),
		(rstate == lmrc_pkg::RLX_FLOW) && (next_rstate == lmrc_pkg::RLX_REST),
		chg_now && !CHARGING, dsg_now && !DISCHARGING};

	always_comb begin
		next_sec_cnt = tick ? 32'h0 : sec_cnt + 32'h1;
		next_rstate = rstate;
		next_quiet_s = quiet_s;
		next_busy_s = busy_s;
		next_relax_s = relax_s;
		next_ocv_done = ocv_done;
		next_ocv_take = 1'b0;
		next_ocv_v = OCV_VOLTAGE;
		case (rstate)
			lmrc_pkg::RLX_FLOW: begin
				if (!quiet) begin
					next_quiet_s = '0;
				end else if (tick) begin
					if (quiet_s >= dsg_rlx || quiet_s >= chg_rlx) begin
						next_rstate = lmrc_pkg::RLX_REST;
						next_relax_s = '0;
						next_busy_s = '0;
						next_ocv_done = 1'b0;
					end else if (quiet_s != 16'hFFFF) begin
						next_quiet_s = quiet_s + 16'h1;
					end
				end
			end
			lmrc_pkg::RLX_REST: begin
				if (!busy) begin
					next_busy_s = '0;
				end else if (tick) begin
					if (busy_s >= quit_rlx) begin
						next_rstate = lmrc_pkg::RLX_FLOW;
						next_quiet_s = '0;
					end else if (busy_s != 16'hFFFF) begin
						next_busy_s = busy_s + 16'h1;
					end
				end
				if (tick && relax_s != 16'hFFFF) begin
					next_relax_s = relax_s + 16'h1;
				end
				if (!ocv_done && relax_s >= lmrc_pkg::OCV_MIN_S) begin
					next_ocv_take = 1'b1;
					next_ocv_done = 1'b1;
					next_ocv_v = CELL_VOLTAGE;
				end
			end
			default: next_rstate = lmrc_pkg::RLX_FLOW;
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			sec_cnt <= '0;
			rstate <= lmrc_pkg::RLX_FLOW;
			quiet_s <= '0;
			busy_s <= '0;
			relax_s <= '0;
			ocv_done <= 1'b0;
			OCV_TAKE <= 1'b0;
			OCV_VOLTAGE <= '0;
			DISCHARGING <= 1'b0;
			CHARGING <= 1'b0;
		end else begin
			sec_cnt <= next_sec_cnt;
			rstate <= next_rstate;
			quiet_s <= next_quiet_s;
			busy_s <= next_busy_s;
			relax_s <= next_relax_s;
			ocv_done <= next_ocv_done;
			OCV_TAKE <= next_ocv_take;
			OCV_VOLTAGE <= next_ocv_v;
			DISCHARGING <= next_dsg;
			CHARGING <= next_chg;
		end
	end

	assign RELAXED = (rstate == lmrc_pkg::RLX_REST);

	// ========================================
	// Cycle averages, filter and rate selection.
	assign p_full = 34'(i_ext) * 34'($signed({1'b0, CELL_VOLTAGE}));
	assign p_cw = 16'(p_full / lmrc_pkg::POWER_DIV);
	assign mp_full = 34'(m_ext) * 34'($signed({1'b0, CELL_VOLTAGE}));
	assign mp_cw = 16'(mp_full / lmrc_pkg::POWER_DIV);
	assign fp_full = 34'(filt[23:8]) * 34'($signed({1'b0, CELL_VOLTAGE}));
	assign fp_cw = 16'(fp_full / lmrc_pkg::POWER_DIV);
	assign f_diff = $signed({MEAN_CURRENT, 8'h00}) - 25'(filt);
	assign f_prod = (34'(f_diff) * 34'($signed({1'b0, lmrc_pkg::FILT_COEF}))) >>> 8;

	lmrc_avg u_avg_i (
		.clk(MCLK),
		.rst_b(RST_B),
		.tick(tick),
		.active(DISCHARGING),
		.sample(INST_CURRENT),
		.run_avg(run_i),
		.last_avg(last_i)
	);

	lmrc_avg u_avg_p (
		.clk(MCLK),
		.rst_b(RST_B),
		.tick(tick),
		.active(DISCHARGING),
		.sample(p_cw),
		.run_avg(run_p),
		.last_avg(last_p)
	);

	always_comb begin
		next_filt = tick ? filt + 24'(f_prod) : filt;
		next_rate = LOAD_RATE;
		if (!model) begin
			case (sel)
				3'h0: next_rate = last_i;
				3'h1: next_rate = run_i;
				3'h2: next_rate = MEAN_CURRENT;
				3'h3: next_rate = filt[23:8];
				3'h4: next_rate = 16'(des_cap / 16'(lmrc_pkg::RATE_DIV));
				3'h5: next_rate = hypo_rate;
				3'h6: next_rate = user_rate;
				default: next_rate = LOAD_RATE;
			endcase
		end else begin
			case (sel)
				3'h0: next_rate = last_p;
				3'h1: next_rate = run_p;
				3'h2: next_rate = mp_cw;
				3'h3: next_rate = fp_cw;
				3'h4: next_rate = 16'(des_en / 16'(lmrc_pkg::RATE_DIV));
				3'h5: next_rate = hypo_rate;
				3'h6: next_rate = user_rate;
				default: next_rate = LOAD_RATE;
			endcase
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			filt <= '0;
			LOAD_RATE <= '0;
			LOAD_MODEL_FLAG <= lmrc_pkg::MODEL_RST;
			LEFT_CAPACITY <= '0;
			LEFT_ENERGY <= '0;
		end else begin
			filt <= next_filt;
			LOAD_RATE <= next_rate;
			LOAD_MODEL_FLAG <= model;
			LEFT_CAPACITY <= (LEFT_RAW_CHARGE > rsv_chg) ? LEFT_RAW_CHARGE - rsv_chg : 16'h0;
			LEFT_ENERGY <= (LEFT_RAW_ENERGY > rsv_en) ? LEFT_RAW_ENERGY - rsv_en : 16'h0;
		end
	end

	// ========================================
	// Assertions.
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_B);

	sequence s_ctrl_wr;
		wr && PADDR == lmrc_pkg::A_CTRL;
	endsequence

	sequence s_bad_sel;
		s_ctrl_wr ##0 PWDATA[lmrc_pkg::CTRL_SEL_LO +: lmrc_pkg::SEL_W] > lmrc_pkg::SEL_MAX;
	endsequence

	model_mirror_a: assert property (s_ctrl_wr |=> ##1 LOAD_MODEL_FLAG == $past(PWDATA[0], 2))
		else $error("model flag does not follow control write");
	sel_hold_a: assert property (s_bad_sel |=> $stable(sel))
		else $error("reserved select changed source");
	dsg_class_a: assert property (DISCHARGING |-> $past(-i_ext > $signed({1'b0, dsg_thr})))
		else $error("discharge flagged below threshold");
	chg_class_a: assert property (CHARGING |-> $past(i_ext > $signed({1'b0, chg_thr})))
		else $error("charge flagged below threshold");
	relax_enter_a: assert property ($rose(RELAXED) |-> $past(quiet && tick))
		else $error("relax entered without quiet current");
	ocv_time_a: assert property (OCV_TAKE |-> $past(relax_s >= lmrc_pkg::OCV_MIN_S) && RELAXED)
		else $error("open-circuit reading before six minutes");
	qmax_slope_a: assert property (qmax_upd |-> VOLT_SLOPE < lmrc_pkg::SLOPE_MAX_UV ##1 QMAX == $past(QMAX_NEW))
		else $error("capacity update with steep slope");
	relax_exit_a: assert property ($fell(RELAXED) |-> $past(busy_s >= quit_rlx && busy))
		else $error("relax left before exit time");
	learn_set_a: assert property (qmax_upd |=> learned[0] [*2])
		else $error("learned bit not set after update");
endmodule

// ### lmrc_pkg.sv
// Summary of operation
// - Model kind selects constant current or power.
// - Status flag mirrors the model kind one clock later.
// - Current mode sources zero to three selectable.
// - Current mode sources four to six selectable.
// - Power mode sources zero to three selectable.
// - Power mode sources four to six selectable.
// - Reserve held back below reported capacity.
// - Discharging only above discharge current threshold.
// - Charging only above charge current threshold.
// - Enter relaxation after quiet relax time.
// - Take open-circuit reading after six minutes.
// - Capacity update needs slope below four.
// - Leave relaxation after exit relax time.
// - Capacity starts configured, updates, stays stored.
// - Learned bit zero set on capacity update.
// - Keep previous cycle average discharge current.
// - Keep previous cycle average discharge power.
package lmrc_pkg;
	// ========================================
	// Register offsets.
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_DSG_THR = 8'h04;
	localparam logic [7:0] A_CHG_THR = 8'h08;
	localparam logic [7:0] A_QUIT = 8'h0C;
	localparam logic [7:0] A_DSG_RLX = 8'h10;
	localparam logic [7:0] A_CHG_RLX = 8'h14;
	localparam logic [7:0] A_QUIT_RLX = 8'h18;
	localparam logic [7:0] A_USER_RATE = 8'h1C;
	localparam logic [7:0] A_HYPO_RATE = 8'h20;
	localparam logic [7:0] A_RESERVE = 8'h24;
	localparam logic [7:0] A_DESIGN = 8'h28;
	localparam logic [7:0] A_QMAX = 8'h2C;
	localparam logic [7:0] A_LEARN = 8'h30;
	localparam logic [7:0] A_STATUS = 8'h34;
	localparam logic [7:0] A_RATE = 8'h38;
	localparam logic [7:0] A_AVG_I = 8'h3C;
	localparam logic [7:0] A_AVG_P = 8'h40;
	localparam logic [7:0] A_IRQ_STAT = 8'h44;
	localparam logic [7:0] A_IRQ_MASK = 8'h48;
	localparam logic [7:0] A_OCV = 8'h4C;
	// ========================================
	// Field positions and reset values.
	localparam int CTRL_MODEL_BIT = 0;
	localparam int CTRL_SEL_LO = 4;
	localparam int SEL_W = 3;
	localparam logic [2:0] SEL_MAX = 3'h6;
	localparam logic [2:0] SEL_RST = 3'h1;
	localparam logic MODEL_RST = 1'b0;
	localparam logic [15:0] DSG_THR_RST = 16'h003C;
	localparam logic [15:0] CHG_THR_RST = 16'h004B;
	localparam logic [15:0] QUIT_RST = 16'h0028;
	localparam logic [15:0] DSG_RLX_RST = 16'h003C;
	localparam logic [15:0] CHG_RLX_RST = 16'h003C;
	localparam logic [15:0] QUIT_RLX_RST = 16'h0001;
	localparam logic [15:0] QMAX_RST = 16'h03E8;
	localparam int LEARN_BIT = 0;
	localparam int ST_MODEL = 0;
	localparam int ST_DSG = 1;
	localparam int ST_CHG = 2;
	localparam int ST_RELAX = 3;
	localparam int ST_OCV = 4;
	localparam int EV_DSG = 0;
	localparam int EV_CHG = 1;
	localparam int EV_ENTER = 2;
	localparam int EV_EXIT = 3;
	localparam int EV_OCV = 4;
	localparam int EV_LEARN = 5;
	localparam int EV_W = 6;
	// ========================================
	// Timing and arithmetic constants.
	localparam int CLK_NS = 10;
	localparam int SEC_NS = 1000000000;
	localparam int SEC_CYCLES_DEF = SEC_NS / CLK_NS;
	localparam int OCV_MIN_MINUTES = 6;
	localparam logic [15:0] OCV_MIN_S = 16'(OCV_MIN_MINUTES * 60);
	localparam logic [15:0] SLOPE_MAX_UV = 16'h0004;
	localparam int FILT_TAU_S = 14;
	localparam logic [8:0] FILT_COEF = 9'(256 / FILT_TAU_S);
	localparam int POWER_DIV = 10000;
	localparam int RATE_DIV = 5;
	typedef enum logic {RLX_FLOW, RLX_REST} lmrc_relax_t;
endpackage

// ### lmrc_avg.sv
`timescale 1ns/1ns
module lmrc_avg (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic tick,
	input wire logic active,
	input wire logic signed [15:0] sample,
	output logic signed [15:0] run_avg,
	output logic signed [15:0] last_avg
);
	// ========================================
	// Cycle accumulator.
	logic signed [47:0] sum, next_sum;
	logic [31:0] cnt, next_cnt;
	logic was_active, next_was_active;
	logic signed [15:0] next_run_avg, next_last_avg;
	logic signed [47:0] quot;

	assign quot = (cnt == 32'h0) ? 48'sh0 : sum / $signed({16'h0000, cnt});

	always_comb begin
		next_sum = sum;
		next_cnt = cnt;
		next_was_active = active;
		next_run_avg = 16'(quot);
		next_last_avg = last_avg;
		if (active && tick) begin
			next_sum = sum + 48'(sample);
			next_cnt = cnt + 32'h1;
		end
		if (!active && was_active) begin
			next_last_avg = run_avg;
			next_sum = '0;
			next_cnt = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sum <= '0;
			cnt <= '0;
			was_active <= 1'b0;
			run_avg <= '0;
			last_avg <= '0;
		end else begin
			sum <= next_sum;
			cnt <= next_cnt;
			was_active <= next_was_active;
			run_avg <= next_run_avg;
			last_avg <= next_last_avg;
		end
	end
endmodule

// ### tb_load_model_relax_control.sv
`timescale 1ns/1ns
module tb_load_model_relax_control;
	// ========================================
	// Stimulus and observed signals.
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [7:0] padr = 8'h00;
	logic [31:0] pwd = 32'h0;
	logic signed [15:0] inst_i = 16'sh0000;
	logic signed [15:0] mean_i = 16'sh0064;
	logic [15:0] volt = 16'h0FA0;
	logic [15:0] slope = 16'h0100;
	logic [15:0] qnew = 16'h0000;
	logic qvalid = 1'b0;
	logic [15:0] raw_q = 16'h0000;
	logic [15:0] raw_e = 16'h0000;
	logic [31:0] prd;
	logic prdy, perr, flag, dsg, chg, rlx, ocv_take, irq;
	logic [15:0] left_q, left_e, ocv_v, qmax;
	logic signed [15:0] rate;
	logic [31:0] r;
	logic e;
	int mismatches = 0;
	int tests_run = 0;
	int n;
	logic [7:0] ctl [9] = '{8'h20, 8'h40, 8'h50, 8'h60, 8'h70, 8'h21, 8'h41, 8'h51, 8'h61};
	logic [15:0] exr [9] = '{16'h0064, 16'h00C8, 16'h0123, 16'h0456, 16'h0456, 16'h0028, 16'h0190, 16'h0123, 16'h0456};

	lmrc_top #(.SEC_CYCLES(10)) dut (.MCLK(mclk), .RST_B(rst_b), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
		.PADDR(padr), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .INST_CURRENT(inst_i),
		.MEAN_CURRENT(mean_i), .CELL_VOLTAGE(volt), .VOLT_SLOPE(slope), .QMAX_NEW(qnew), .QMAX_NEW_VALID(qvalid),
		.LEFT_RAW_CHARGE(raw_q), .LEFT_RAW_ENERGY(raw_e), .LEFT_CAPACITY(left_q), .LEFT_ENERGY(left_e),
		.LOAD_MODEL_FLAG(flag), .LOAD_RATE(rate), .DISCHARGING(dsg), .CHARGING(chg), .RELAXED(rlx),
		.OCV_TAKE(ocv_take), .OCV_VOLTAGE(ocv_v), .QMAX(qmax), .IRQ(irq));

	initial begin
		forever #5 mclk = ~mclk;
	end

	// ========================================
	// Shared tasks.
	task complete_run;
		$display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task cyc(input int k);
		repeat (k) @(posedge mclk);
	endtask

	task acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] x, input logic xe);
		psel <= 1'b1;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge mclk);
		pen <= 1'b1;
		do begin
			@(posedge mclk);
		end while (prdy !== 1'b1);
		r = prd;
		e = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge mclk);
		if (!w) begin
			chk(r, x);
		end
		chk({31'h0, e}, {31'h0, xe});
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		acc(1'b1, a, d, 32'h0, 1'b0);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] x);
		acc(1'b0, a, 32'h0, x, 1'b0);
	endtask

	// ========================================
	// Test sequence.
	initial begin
		cyc(20);
		rst_b <= 1'b1;
		cyc(1);
		rd(lmrc_pkg::A_CTRL, 32'h10);
		chk({31'h0, flag}, 32'h0);
		chk({16'h0, qmax}, 32'h03E8);
		rd(lmrc_pkg::A_DSG_THR, 32'h3C);
		acc(1'b0, 8'h80, 32'h0, 32'h0, 1'b1);
		acc(1'b1, 8'h80, 32'h5, 32'h0, 1'b1);
		inst_i <= -16'sd200;
		n = 0;
		while (rate === 16'sh0000 && n < 40) begin
			@(posedge mclk);
			n++;
		end
		cyc(44);
		chk({16'h0, rate}, 32'hFF38);
		inst_i <= 16'sh0000;
		cyc(10);
		wr(lmrc_pkg::A_CTRL, 32'h00);
		cyc(3);
		chk({16'h0, rate}, 32'hFF38);
		acc(1'b0, lmrc_pkg::A_AVG_I, 32'h0, 32'h0000FF38, 1'b0);
		chk({16'h0, r[15:0]}, 32'hFF38);
		acc(1'b0, lmrc_pkg::A_AVG_P, 32'h0, 32'h0000FFB0, 1'b0);
		chk({16'h0, r[15:0]}, 32'hFFB0);
		wr(lmrc_pkg::A_CTRL, 32'h01);
		cyc(3);
		chk({16'h0, rate}, 32'hFFB0);
		chk({31'h0, flag}, 32'h1);
		inst_i <= -16'sd60;
		cyc(3);
		chk({31'h0, dsg}, 32'h0);
		inst_i <= -16'sd61;
		cyc(3);
		chk({31'h0, dsg}, 32'h1);
		inst_i <= 16'sd75;
		cyc(3);
		chk({30'h0, chg, dsg}, 32'h0);
		inst_i <= 16'sd76;
		cyc(3);
		chk({31'h0, chg}, 32'h1);
		chk({31'h0, irq}, 32'h0);
		inst_i <= 16'sh0000;
		wr(lmrc_pkg::A_HYPO_RATE, 32'h0123);
		wr(lmrc_pkg::A_USER_RATE, 32'h0456);
		wr(lmrc_pkg::A_DESIGN, 32'h07D0_03E8);
		for (int i = 0; i < 9; i++) begin
			wr(lmrc_pkg::A_CTRL, {24'h0, ctl[i]});
			cyc(3);
			chk({16'h0, rate}, {16'h0, exr[i]});
			chk({31'h0, flag}, {31'h0, ctl[i][0]});
		end
		wr(lmrc_pkg::A_RESERVE, 32'h0010_0020);
		raw_q <= 16'h0100;
		raw_e <= 16'h0050;
		cyc(3);
		chk({left_e, left_q}, 32'h0040_00E0);
		raw_q <= 16'h0010;
		cyc(3);
		chk({16'h0, left_q}, 32'h0);
		wr(lmrc_pkg::A_QUIT, 32'h28);
		wr(lmrc_pkg::A_DSG_RLX, 32'h2);
		wr(lmrc_pkg::A_CHG_RLX, 32'h3);
		volt <= 16'h0ED8;
		mean_i <= 16'sh0000;
		cyc(10);
		chk({31'h0, rlx}, 32'h0);
		cyc(40);
		chk({31'h0, rlx}, 32'h1);
		n = 0;
		while (ocv_take !== 1'b1 && n < 5000) begin
			@(posedge mclk);
			n++;
		end
		chk({31'h0, n > 3400 && n < 3700}, 32'h1);
		cyc(1);
		chk({16'h0, ocv_v}, 32'h0ED8);
		slope <= 16'h0004;
		qnew <= 16'h0500;
		qvalid <= 1'b1;
		cyc(5);
		chk({16'h0, qmax}, 32'h03E8);
		slope <= 16'h0003;
		cyc(3);
		chk({16'h0, qmax}, 32'h0500);
		qvalid <= 1'b0;
		rd(lmrc_pkg::A_LEARN, 32'h1);
		chk({31'h0, irq}, 32'h0);
		wr(lmrc_pkg::A_IRQ_MASK, 32'h20);
		chk({31'h0, irq}, 32'h1);
		rd(lmrc_pkg::A_IRQ_STAT, 32'h37);
		chk({31'h0, irq}, 32'h0);
		mean_i <= 16'sd100;
		cyc(10);
		mean_i <= 16'sh0000;
		cyc(20);
		chk({31'h0, rlx}, 32'h1);
		mean_i <= 16'sd100;
		cyc(40);
		chk({31'h0, rlx}, 32'h0);
		rd(lmrc_pkg::A_IRQ_STAT, 32'h08);
		complete_run();
	end

	// ========================================
	// Watchdog cuts a hang short.
	initial begin
		cyc(30000);
		mismatches++;
		complete_run();
	end
endmodule
